// File: mssc_pkg.sv
// Shared constants and types of the margin slew safe-state controller
package mssc_pkg;

  // ************************************************************
  // Widths and clock
  // ************************************************************
  localparam int MSSC_DW = 12;
  localparam int MSSC_TW = 21;
  localparam real MSSC_CLK_NS = 5.0;
  localparam logic [6:0] MSSC_ADDR_DEF = 7'h30;
  localparam logic [7:0] MSSC_PM_REV = 8'h11;

  // ************************************************************
  // Step period and step size tables
  // ************************************************************
  typedef int unsigned mssc_tab_t [16];
  localparam real MSSC_PERIOD_US [16] = '{0.0, 4.0, 8.0, 12.0, 18.0, 27.0, 40.5, 60.75,
    91.13, 136.69, 239.2, 418.61, 732.56, 1281.98, 2563.96, 5127.92};

  // Least time per step, rounded up to whole clocks
  function automatic mssc_tab_t mssc_cycles();
    mssc_tab_t t;
    for (int i = 0; i < 16; i++) begin
      t[i] = int'($ceil(MSSC_PERIOD_US[i] * 1000.0 / MSSC_CLK_NS - 0.001));
    end
    return t;
  endfunction

  localparam mssc_tab_t MSSC_PERIOD_CYC = mssc_cycles();
  localparam logic [5:0] MSSC_STEP_LSB [8] = '{6'h01, 6'h02, 6'h03, 6'h04,
    6'h06, 6'h08, 6'h10, 6'h20};
  localparam logic [3:0] MSSC_NO_SLEW = 4'h0;

  // ************************************************************
  // Safe-state selections, commands and operation bytes
  // ************************************************************
  localparam logic [1:0] MSSC_SAFE_HIZ = 2'h0;
  localparam logic [1:0] MSSC_SAFE_NVM = 2'h1;
  localparam logic [1:0] MSSC_SAFE_LOW = 2'h2;
  localparam logic [1:0] MSSC_SAFE_HIGH = 2'h3;
  localparam logic [7:0] MSSC_CMD_OPER = 8'h01;
  localparam logic [7:0] MSSC_CMD_CML = 8'h7e;
  localparam logic [7:0] MSSC_CMD_REV = 8'h98;
  localparam int MSSC_CML_BIT = 1;
  localparam logic [7:0] MSSC_OP_OFF = 8'h00;
  localparam logic [7:0] MSSC_OP_ON = 8'h80;
  localparam logic [7:0] MSSC_OP_MLOW = 8'h94;
  localparam logic [7:0] MSSC_OP_MHIGH = 8'ha4;
  localparam logic [15:0] MSSC_NO_DATA = 16'hffff;
  localparam logic [1:0] MSSC_MAX_BYTES = 2'h2;
  localparam logic [3:0] MSSC_BYTE_BITS = 4'h8;

  typedef enum logic [1:0] {ls_idle, ls_addr, ls_cmd, ls_data} mssc_lst_t;
  typedef enum logic [1:0] {cs_idle, cs_slew, cs_safe_slew, cs_safe_hiz} mssc_cst_t;

endpackage

// File: mssc_if.sv
// Command and response carrier between link and sequencer
`timescale 1ns/10ps
`default_nettype none
interface mssc_if;
  logic [7:0] cmd;
  logic wr_tgl;
  logic [15:0] wr_data;
  logic rd_tgl;
  logic rsp_tgl;
  logic [15:0] rsp_data;
  modport link (output cmd, wr_tgl, wr_data, rd_tgl, input rsp_tgl, rsp_data);
  modport core (input cmd, wr_tgl, wr_data, rd_tgl, output rsp_tgl, rsp_data);
endinterface
`default_nettype wire

// File: mssc_sync.sv
// Two-stage level synchroniser
`timescale 1ns/10ps
`default_nettype none
module mssc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] out;
  } mssc_sync_t;
  mssc_sync_t s_q;
  mssc_sync_t s_d;

  always_comb begin
    s_d.meta = d;
    s_d.out = s_q.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.out;
endmodule
`default_nettype wire

// File: mssc_link.sv
// Two-wire command receiver on the link clock
`timescale 1ns/10ps
`default_nettype none
module mssc_link
  import mssc_pkg::*;
#(
  parameter logic [6:0] ADDR = MSSC_ADDR_DEF
) (
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic pm_en,
  mssc_if.link bus,
  output logic sda_o,
  output logic sda_oe
);
  typedef struct packed {
    logic scl_p;
    logic sda_p;
    mssc_lst_t st;
    logic [3:0] cnt;
    logic in_ack;
    logic tx;
    logic [7:0] sh;
    logic [7:0] txb;
    logic [1:0] nb;
    logic [7:0] cmd;
    logic [15:0] data;
    logic wr_tgl;
    logic rd_tgl;
    logic sda_oe;
    logic sda_o;
  } mssc_link_t;
  mssc_link_t q;
  mssc_link_t d;
  logic [3:0] syn_s;
  logic [15:0] word;

  mssc_sync #(.W(4)) u_sync (
    .clk(link_clk),
    .rst(link_rst),
    .d({scl_i, sda_i, pm_en, bus.rsp_tgl}),
    .q(syn_s)
  );

  always_comb begin
    d = q;
    word = (syn_s[0] == q.rd_tgl) ? bus.rsp_data : MSSC_NO_DATA;
    d.scl_p = syn_s[3];
    d.sda_p = syn_s[2];
    // start and stop frame each run
    if (syn_s[3] && q.scl_p && q.sda_p && !syn_s[2]) begin
      d.st = ls_addr;
      d.cnt = '0;
      d.in_ack = 1'b0;
      d.tx = 1'b0;
      d.sda_oe = 1'b0;
    end else if (syn_s[3] && q.scl_p && !q.sda_p && syn_s[2]) begin
      // assembled write word issued at stop
      if (!q.tx && q.st == ls_data && q.nb != '0) begin
        d.wr_tgl = ~q.wr_tgl;
      end
      d.st = ls_idle;
      d.sda_oe = 1'b0;
      d.in_ack = 1'b0;
      d.tx = 1'b0;
    end else if (q.st != ls_idle && syn_s[3] && !q.scl_p) begin
      if (q.in_ack) begin
        // Host refuses further read bytes
        if (q.tx && syn_s[2]) begin
          d.st = ls_idle;
        end
      end else begin
        d.cnt = q.cnt + 4'h1;
        d.sh = {q.sh[6:0], syn_s[2]};
      end
    end else if (q.st != ls_idle && !syn_s[3] && q.scl_p) begin
      if (q.in_ack) begin
        d.in_ack = 1'b0;
        d.cnt = '0;
        d.sda_oe = q.tx & ~q.txb[7];
      end else if (q.cnt == MSSC_BYTE_BITS) begin
        d.in_ack = 1'b1;
        d.sda_oe = ~q.tx;
        if (q.tx) begin
          // next byte, low byte went first
          d.txb = q.data[7:0];
          d.data = {8'hff, q.data[15:8]};
        end else begin
          case (q.st)
            ls_addr: begin
              if (q.sh[7:1] == ADDR && syn_s[1]) begin
                d.st = ls_cmd;
                if (q.sh[0]) begin
                  d.tx = 1'b1;
                  d.txb = word[7:0];
                  d.data = {8'hff, word[15:8]};
                end
              end else begin
                // no answer to another address or while protocol is off
                d.sda_oe = 1'b0;
                d.st = ls_idle;
              end
            end
            ls_cmd: begin
              d.cmd = q.sh;
              d.rd_tgl = ~q.rd_tgl;
              d.st = ls_data;
              d.nb = '0;
            end
            ls_data: begin
              if (q.nb == '0) begin
                d.data[7:0] = q.sh;
              end else if (q.nb == 2'h1) begin
                d.data[15:8] = q.sh;
              end
              if (q.nb != MSSC_MAX_BYTES) begin
                d.nb = q.nb + 2'h1;
              end
            end
            default: d.sda_oe = 1'b0;
          endcase
        end
      end else if (q.tx) begin
        d.txb = {q.txb[6:0], 1'b1};
        d.sda_oe = ~q.txb[6];
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.cmd = q.cmd;
  assign bus.wr_tgl = q.wr_tgl;
  assign bus.wr_data = q.data;
  assign bus.rd_tgl = q.rd_tgl;
  assign sda_o = q.sda_o;
  assign sda_oe = q.sda_oe;
endmodule
`default_nettype wire

// File: mssc_top.sv
// Output code sequencer with safe state, stepping and power-bus commands
`timescale 1ns/10ps
`default_nettype none
module mssc_top
  import mssc_pkg::*;
#(
  parameter int DW = MSSC_DW,
  parameter logic [6:0] ADDR = MSSC_ADDR_DEF,
  parameter mssc_tab_t PERIOD_CYC = MSSC_PERIOD_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic pm_en,
  input wire logic [DW-1:0] nvm_code,
  input wire logic [DW-1:0] margin_hi,
  input wire logic [DW-1:0] margin_lo,
  input wire logic [2:0] step_size,
  input wire logic [3:0] step_period,
  input wire logic [1:0] safe_sel,
  input wire logic protect_pin,
  input wire logic protect_trig,
  input wire logic code_wr,
  input wire logic [DW-1:0] code_wdata,
  input wire logic status_rd,
  output logic [DW-1:0] dac_code,
  output logic dac_hiz,
  output logic slewing,
  output logic protect_busy,
  output logic protect_flag,
  output logic cml_flag
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic wr_p;
    logic rd_p;
    logic pin_p;
    mssc_cst_t st;
    logic [DW-1:0] code;
    logic [DW-1:0] target;
    logic hiz;
    logic slew;
    logic [MSSC_TW-1:0] tick;
    logic busy;
    logic flag;
    logic cml;
    logic [7:0] op;
    logic rsp_tgl;
    logic [15:0] rsp;
  } mssc_core_t;

  mssc_core_t q;
  mssc_core_t d;
  logic [2:0] syn_s;
  logic wr_ev;
  logic rd_ev;
  logic trig;
  logic jump;
  logic [DW-1:0] step;
  logic [MSSC_TW-1:0] per_last;

  mssc_if u_if ();

  // ************************************************************
  // Link side and crossings
  // ************************************************************
  mssc_link #(.ADDR(ADDR)) u_link (
    .link_clk(link_clk),
    .link_rst(link_rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .pm_en(pm_en),
    .bus(u_if.link),
    .sda_o(sda_o),
    .sda_oe(sda_oe)
  );

  // Toggles and the protect pin only: the word beside each toggle is loaded no later than the edge it flips on and holds after
  mssc_sync #(.W(3)) u_sync (
    .clk(sys_clk),
    .rst(rst),
    .d({u_if.wr_tgl, u_if.rd_tgl, protect_pin}),
    .q(syn_s)
  );

  // ************************************************************
  // Move setup
  // ************************************************************
  function automatic mssc_core_t mssc_move(mssc_core_t s, logic [DW-1:0] tgt,
                                           logic safe, logic now);
    mssc_core_t r;
    r = s;
    if (now) begin
      r.code = tgt;
      r.st = safe ? cs_safe_hiz : cs_idle;
    end else begin
      r.target = tgt;
      r.tick = '0;
      r.st = safe ? cs_safe_slew : cs_slew;
    end
    return r;
  endfunction

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb begin
    d = q;
    wr_ev = syn_s[2] ^ q.wr_p;
    rd_ev = syn_s[1] ^ q.rd_p;
    trig = (syn_s[0] & ~q.pin_p) | protect_trig;
    // zero period means a single jump
    jump = (step_period == MSSC_NO_SLEW);
    step = DW'(MSSC_STEP_LSB[step_size]);
    per_last = MSSC_TW'(PERIOD_CYC[step_period] - 1);
    d.wr_p = syn_s[2];
    d.rd_p = syn_s[1];
    d.pin_p = syn_s[0];

    if (q.st == cs_slew || q.st == cs_safe_slew) begin
      d.tick = q.tick + 1'b1;
      if (q.tick >= per_last) begin
        d.tick = '0;
        if (q.code < q.target) begin
          d.code = (q.target - q.code <= step) ? q.target : q.code + step;
        end else begin
          d.code = (q.code - q.target <= step) ? q.target : q.code - step;
        end
        if (d.code == q.target) begin
          d.st = cs_idle;
          if (q.st == cs_safe_slew) begin
            d.hiz = 1'b1;
            d.busy = 1'b0;
          end
        end
      end
    end
    // Hi-Z one clock after the direct load
    if (q.st == cs_safe_hiz) begin
      d.hiz = 1'b1;
      d.busy = 1'b0;
      d.st = cs_idle;
    end

    if (status_rd && !q.busy) begin
      d.flag = 1'b0;
    end
    // code write is applied at once
    if (code_wr && !q.busy) begin
      d.code = code_wdata;
    end

    if (wr_ev && pm_en && !q.busy) begin
      if (u_if.cmd == MSSC_CMD_OPER) begin
        d.op = u_if.wr_data[7:0];
        if (u_if.wr_data[7:0] == MSSC_OP_OFF) begin
          d.hiz = 1'b1;
        end else if (u_if.wr_data[7:0] == MSSC_OP_ON) begin
          d.hiz = 1'b0;
        end else if (u_if.wr_data[7:0] == MSSC_OP_MLOW) begin
          d = mssc_move(d, margin_lo, 1'b0, jump);
        end else if (u_if.wr_data[7:0] == MSSC_OP_MHIGH) begin
          d = mssc_move(d, margin_hi, 1'b0, jump);
        end else begin
          d.cml = 1'b1;
        end
      end else if (u_if.cmd == MSSC_CMD_CML) begin
        // Fault bit clears by writing one
        if (u_if.wr_data[MSSC_CML_BIT]) begin
          d.cml = 1'b0;
        end
      end else begin
        d.cml = 1'b1;
      end
    end

    if (rd_ev) begin
      d.rsp_tgl = ~q.rsp_tgl;
      d.rsp = '0;
      if (u_if.cmd == MSSC_CMD_OPER) begin
        d.rsp[7:0] = q.op;
      end else if (u_if.cmd == MSSC_CMD_CML) begin
        d.rsp[MSSC_CML_BIT] = q.cml;
      end else if (u_if.cmd == MSSC_CMD_REV) begin
        d.rsp[7:0] = MSSC_PM_REV;
      end else begin
        d.cml = 1'b1;
      end
    end

    // Trigger last so the fields it sets override any move or write in the same clock
    if (trig && !q.busy) begin
      d.busy = 1'b1;
      d.flag = 1'b1;
      case (safe_sel)
        MSSC_SAFE_HIZ: begin
          d.hiz = 1'b1;
          d.busy = 1'b0;
          d.st = cs_idle;
        end
        MSSC_SAFE_NVM: begin
          d.code = nvm_code;
          d.st = cs_safe_hiz;
        end
        MSSC_SAFE_LOW: begin
          d = mssc_move(d, margin_lo, 1'b1, jump);
        end
        default: begin
          d = mssc_move(d, margin_hi, 1'b1, jump);
        end
      endcase
    end
    // Registered so the move flag leaves straight from a flip-flop
    d.slew = (d.st == cs_slew) || (d.st == cs_safe_slew);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      // Channels come up powered down
      q.hiz <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign u_if.rsp_tgl = q.rsp_tgl;
  assign u_if.rsp_data = q.rsp;
  assign dac_code = q.code;
  assign dac_hiz = q.hiz;
  assign slewing = q.slew;
  assign protect_busy = q.busy;
  assign protect_flag = q.flag;
  assign cml_flag = q.cml;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  chk_safe_hiz: assert property (
    trig && !q.busy && safe_sel == MSSC_SAFE_HIZ |=> q.hiz && !q.busy && q.flag)
    else $error("hiz safe state not immediate");

  chk_safe_nvm: assert property (
    trig && !q.busy && safe_sel == MSSC_SAFE_NVM
    |=> (q.code == $past(nvm_code) && q.busy) ##1 (q.hiz && !q.busy))
    else $error("stored code safe state wrong");

  chk_safe_low: assert property (
    trig && !q.busy && safe_sel == MSSC_SAFE_LOW && !jump
    |=> q.st == cs_safe_slew && q.target == $past(margin_lo))
    else $error("low margin safe move not started");

  chk_safe_high: assert property (
    trig && !q.busy && safe_sel == MSSC_SAFE_HIGH && !jump
    |=> q.st == cs_safe_slew && q.target == $past(margin_hi))
    else $error("high margin safe move not started");

  chk_code_write: assert property (
    code_wr && !q.busy && !trig && !wr_ev && q.st == cs_idle
    |=> q.code == $past(code_wdata))
    else $error("code write not applied");

  chk_step_period: assert property (
    q.st == cs_slew && $past(q.st) == cs_slew && $changed(q.code)
    |-> $past(q.tick) == $past(per_last))
    else $error("step taken off period");

  chk_step_clamp: assert property (
    q.st == cs_slew && q.code < q.target && !code_wr && !trig && !wr_ev
    |=> q.code <= $past(q.target) && q.code - $past(q.code) <= $past(step))
    else $error("step overshoot or too large");

  chk_jump: assert property (
    wr_ev && pm_en && !q.busy && !trig && jump && u_if.cmd == MSSC_CMD_OPER
    && u_if.wr_data[7:0] == MSSC_OP_MHIGH |=> q.code == $past(margin_hi))
    else $error("no-slew margin did not jump");

  chk_busy_ignore: assert property (
    q.busy && wr_ev |=> $stable(q.op))
    else $error("write accepted during safe sequence");

  chk_flag_hold: assert property (
    q.flag && q.busy |=> q.flag)
    else $error("flag cleared before completion");

  chk_pm_gate: assert property (
    !pm_en && wr_ev |=> $stable(q.op) && $stable(q.hiz))
    else $error("command taken with protocol off");

endmodule
`default_nettype wire

// File: mssc_host.sv
// Host model driving the two-wire power-bus pins
`timescale 1ns/10ps
`default_nettype none
module mssc_host (
  input wire logic link_clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Six link clocks per phase keeps each level well past the four-clock minimum
  task automatic hold();
    repeat (6) @(posedge link_clk);
  endtask
  task automatic clk_bit(input logic b, output logic s);
    sda_low <= !b;
    hold();
    scl <= 1'b1;
    hold();
    s = sda_in;
    scl <= 1'b0;
  endtask
  task automatic start();
    sda_low <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b0;
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_low <= 1'b0;
    hold();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], s);
      rx[i] = s;
    end
    clk_bit(!mack, s);
    ack = !s;
  endtask
endmodule
`default_nettype wire

// File: margin_slew_safe_state_ctrl_test.sv
// Self-checking bench of the margin slew safe-state controller
`timescale 1ns/10ps
`default_nettype none
module margin_slew_safe_state_ctrl_test
  import mssc_pkg::*;
;
  localparam mssc_tab_t PC = '{0, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18};
  localparam logic [6:0] ADDR = MSSC_ADDR_DEF;
  logic sys_clk = 1'b0, rst = 1'b1, link_clk, link_rst = 1'b1, pm_en = 1'b0;
  logic scl, host_low, sda_o, sda_oe, protect_pin = 1'b0, protect_trig = 1'b0;
  logic code_wr = 1'b0, status_rd = 1'b0, dac_hiz, slewing, protect_busy;
  logic protect_flag, cml_flag, ok;
  logic [11:0] nvm_code = 12'h5a5, margin_hi = 12'h200, margin_lo = 12'h100;
  logic [11:0] code_wdata = 12'h000, dac_code, st, tg;
  logic [2:0] step_size = 3'h0;
  logic [3:0] step_period = 4'h0;
  logic [1:0] safe_sel = 2'h0;
  logic [15:0] rd;
  int miscompares = 0, cmp_count = 0, cyc = 0, k, j, n;
  int stp[8] = '{1, 2, 3, 4, 6, 8, 16, 32};
  wire logic sda_line = !(host_low || (sda_oe && !sda_o));
  always #2.5 sys_clk = ~sys_clk;
  initial begin
    link_clk = 1'b0;
    #1.2;
    forever #7.5 link_clk = ~link_clk;
  end
  mssc_host mssc_host_i (.link_clk(link_clk), .sda_in(sda_line), .scl(scl), .sda_low(host_low));
  mssc_top #(.PERIOD_CYC(PC)) mssc_top_i (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
    .link_rst(link_rst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .pm_en(pm_en), .nvm_code(nvm_code), .margin_hi(margin_hi), .margin_lo(margin_lo),
    .step_size(step_size), .step_period(step_period), .safe_sel(safe_sel),
    .protect_pin(protect_pin), .protect_trig(protect_trig), .code_wr(code_wr),
    .code_wdata(code_wdata), .status_rd(status_rd), .dac_code(dac_code), .dac_hiz(dac_hiz),
    .slewing(slewing), .protect_busy(protect_busy), .protect_flag(protect_flag),
    .cml_flag(cml_flag));
  // ************************************************************
  // Access and comparison tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr_code(input logic [11:0] v);
    @(posedge sys_clk) code_wr <= 1'b1;
    code_wdata <= v;
    @(posedge sys_clk) code_wr <= 1'b0;
    @(posedge sys_clk) #1;
  endtask
  task automatic rd_status();
    @(posedge sys_clk) status_rd <= 1'b1;
    @(posedge sys_clk) status_rd <= 1'b0;
    @(posedge sys_clk) #1;
  endtask
  // Ends on the taking edge of the trigger
  task automatic trig(input logic [1:0] sel);
    @(posedge sys_clk) protect_trig <= 1'b1;
    safe_sel <= sel;
    @(posedge sys_clk) protect_trig <= 1'b0;
  endtask
  task automatic pm_wr(input logic [7:0] cmd, input logic [15:0] d, input int nb);
    logic [7:0] rx;
    logic a;
    mssc_host_i.start();
    mssc_host_i.xfer({ADDR, 1'b0}, 1'b0, rx, ok);
    mssc_host_i.xfer(cmd, 1'b0, rx, a);
    ok &= a;
    for (int i = 0; i < nb; i++) begin
      mssc_host_i.xfer(d[8*i+:8], 1'b0, rx, a);
      ok &= a;
    end
    mssc_host_i.stop();
    repeat (20) @(posedge sys_clk);
    #1;
  endtask
  task automatic pm_rd(input logic [7:0] cmd, output logic [15:0] d);
    logic [7:0] rx;
    logic a;
    mssc_host_i.start();
    mssc_host_i.xfer({ADDR, 1'b0}, 1'b0, rx, a);
    mssc_host_i.xfer(cmd, 1'b0, rx, a);
    mssc_host_i.start();
    mssc_host_i.xfer({ADDR, 1'b1}, 1'b0, rx, a);
    mssc_host_i.xfer(8'hff, 1'b1, d[7:0], a);
    mssc_host_i.xfer(8'hff, 1'b0, d[15:8], a);
    mssc_host_i.stop();
  endtask
  // Hang guard, about half again above the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      finish_test();
    end
  end
  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    link_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check(16'({dac_hiz, protect_flag, cml_flag, slewing}), 16'h0008);
    @(posedge sys_clk) pm_en <= 1'b1;
    // Output powered up before each safe test but the last, so Hi-Z is seen to arrive
    pm_wr(MSSC_CMD_OPER, 16'h0080, 1);
    check(16'(dac_hiz), 16'h0000);
    wr_code(12'h123);
    check(16'(dac_code), 16'h0123);
    trig(2'h0);
    @(posedge sys_clk) #1;
    check(16'({dac_hiz, protect_flag, protect_busy}), 16'h0006);
    rd_status();
    check(16'(protect_flag), 16'h0000);
    pm_wr(MSSC_CMD_OPER, 16'h0080, 1);
    check(16'(dac_hiz), 16'h0000);
    trig(2'h1);
    // Raised on the taking edge so the next edge sees it while busy
    code_wr <= 1'b1;
    code_wdata <= 12'h777;
    #1;
    check(16'({protect_busy, dac_code}), 16'h15a5);
    @(posedge sys_clk) code_wr <= 1'b0;
    #1;
    check(16'({dac_hiz, protect_busy}), 16'h0002);
    @(posedge sys_clk) #1;
    check(16'(dac_code), 16'h05a5);
    for (int sel = 2; sel < 4; sel++) begin
      for (int s = 0; s < 8; s++) begin
        tg = (sel == 2) ? margin_lo : margin_hi;
        st = (sel == 2) ? tg + 12'd40 : tg - 12'd40;
        @(posedge sys_clk) step_size <= 3'(s);
        step_period <= 4'h1;
        wr_code(st);
        pm_wr(MSSC_CMD_OPER, 16'h0080, 1);
        check(16'(dac_hiz), 16'h0000);
        trig(2'(sel));
        k = 0;
        do begin
          @(posedge sys_clk) #1;
          k++;
        end while (dac_code === st && k < 50);
        check(16'(k), 16'(PC[1]));
        check(16'(dac_code), (sel == 2) ? 16'(st - stp[s]) : 16'(st + stp[s]));
        check(16'(slewing), 16'h0001);
        j = 0;
        while (protect_busy === 1'b1 && j < 1000) begin
          @(posedge sys_clk) #1;
          j++;
        end
        n = PC[1] * ((40 + stp[s] - 1) / stp[s]);
        check(16'(k + j >= n && k + j <= n + 2), 16'h0001);
        check(16'({dac_hiz, dac_code}), 16'({1'b1, tg}));
      end
    end
    pm_wr(MSSC_CMD_OPER, 16'h0080, 1);
    check(16'(dac_hiz), 16'h0000);
    rd_status();
    @(posedge sys_clk) safe_sel <= 2'h0;
    protect_pin <= 1'b1;
    j = 0;
    while (protect_flag !== 1'b1 && j < 8) begin
      @(posedge sys_clk) #1;
      j++;
    end
    check(16'({protect_flag, dac_hiz}), 16'h0003);
    @(posedge sys_clk) protect_pin <= 1'b0;
    step_period <= 4'h0;
    pm_en <= 1'b0;
    pm_wr(MSSC_CMD_OPER, 16'h0080, 1);
    check(16'({ok, dac_hiz}), 16'h0001);
    @(posedge sys_clk) pm_en <= 1'b1;
    pm_wr(MSSC_CMD_OPER, 16'h0080, 1);
    check(16'({ok, dac_hiz}), 16'h0002);
    pm_wr(MSSC_CMD_OPER, 16'h0094, 1);
    check(16'(dac_code), 16'(margin_lo));
    @(posedge sys_clk) step_period <= 4'h2;
    step_size <= 3'h7;
    pm_wr(MSSC_CMD_OPER, 16'h00a4, 1);
    check(16'(slewing), 16'h0001);
    j = 0;
    while (slewing === 1'b1 && j < 1000) begin
      @(posedge sys_clk) #1;
      j++;
    end
    check(16'(dac_code), 16'(margin_hi));
    pm_rd(MSSC_CMD_OPER, rd);
    check(16'(rd[7:0]), 16'h00a4);
    pm_rd(MSSC_CMD_REV, rd);
    check(16'(rd[7:0]), 16'(MSSC_PM_REV));
    pm_wr(8'h55, 16'h0000, 1);
    check(16'(cml_flag), 16'h0001);
    pm_wr(MSSC_CMD_CML, 16'h0200, 2);
    check(16'(cml_flag), 16'h0001);
    pm_wr(MSSC_CMD_CML, 16'h0002, 2);
    check(16'(cml_flag), 16'h0000);
    @(posedge sys_clk) step_period <= 4'hf;
    step_size <= 3'h0;
    pm_wr(MSSC_CMD_OPER, 16'h0000, 1);
    wr_code(12'h080);
    trig(2'h2);
    // Long safe move, so this bus write lands while the sequence runs
    pm_wr(MSSC_CMD_OPER, 16'h0080, 1);
    check(16'({protect_busy, dac_hiz}), 16'h0003);
    rd_status();
    check(16'(protect_flag), 16'h0001);
    j = 0;
    while (protect_busy === 1'b1 && j < 3000) begin
      @(posedge sys_clk) #1;
      j++;
    end
    check(16'({dac_hiz, dac_code}), 16'({1'b1, margin_lo}));
    finish_test();
  end
endmodule
`default_nettype wire
